// File: verilog/pesc_top.sv
// Purpose: Event status, interrupt enables and saturating error counters of a PHY
// Assumes: Event inputs are single-cycle pulses from logic on I_CLOCK
// Notes: Registers reached over classic Wishbone, 32-bit data, low 16 bits used
// Function
// - Each event except jabber sets its status bit until the register is next read.
// - Interrupt needs event enable plus both global control bits set.
// - Status bits set whether or not the matching enable is set.
// - Reserved bits 15 and 7 of second status ignore writes, read zero.
// - Bit 14 flags autonegotiation error, resets zero, clears on read.
// - Bit 13 flags page received, resets zero, clears on read.
// - Bit 12 flags loopback FIFO over or underflow, clears on read.
// - Bit 11 flags crossover state change, resets zero, clears on read.
// - Bit 10 flags sleep mode event, resets zero, clears on read.
// - Bit 9 flags receive polarity change, resets zero, clears on read.
// - Bit 8 shows jabber, read only, resets zero, not cleared by reading.
// - Bits 6 to 0 are read-write event enables, reset zero.
// - Eight-bit false carrier count rises once per false carrier event.
// - False carrier count holds at FFh instead of wrapping.
// - False carrier count passing 7Fh raises a half-full event.
// - Reading false carrier register zeroes it; bits 15:8 read zero.
// - Receive error count rises per error with carrier and data valid.
// - Receive error count frozen during MII loopback.
// - Receive error count holds at FFFFh instead of wrapping.
// - Receive error count passing 7FFFh raises event; read clears it.
// - Half-full events latch in first status bits 9, 8, enabled by 1, 0.
// - Control bit 1 enables event interrupts, bit 0 makes pin active-low irq.
`timescale 1ns/1ps
module pesc_top
  import pesc_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [DATA_W-1:0] I_WB_DAT,
  output logic [DATA_W-1:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_AN_ERR_EVT,
  input wire logic I_PAGE_RX_EVT,
  input wire logic I_LB_FIFO_EVT,
  input wire logic I_XOVER_CHG_EVT,
  input wire logic I_SLEEP_EVT,
  input wire logic I_POL_CHG_EVT,
  input wire logic I_JABBER,
  input wire logic I_FALSE_CARRIER_EVT,
  input wire logic I_RX_ERR_EVT,
  input wire logic I_CARRIER_VALID,
  input wire logic I_RX_DV,
  input wire logic I_MII_LOOPBACK,
  output logic O_IRQ_N,
  output logic O_IRQ_OE
);

  logic ack_q;
  logic [DATA_W-1:0] rdat_q;
  logic [DATA_W-1:0] rdat_d;
  logic take;
  logic rd_take;
  logic wr_take;
  logic [IDX_W-1:0] idx;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] st2_q;
  logic [NUM_EVT-1:0] en2_q;
  logic [1:0] st1_q;
  logic [1:0] en1_q;
  logic [1:0] ctrl_q;
  logic [FC_W-1:0] fc_q;
  logic [FC_W-1:0] fc_d;
  logic [RE_W-1:0] re_q;
  logic [RE_W-1:0] re_d;
  logic clr_st2;
  logic clr_st1;
  logic clr_fc;
  logic clr_re;
  logic fc_inc;
  logic re_evt;
  logic re_inc;
  logic fc_hf_evt;
  logic re_hf_evt;
  logic irq_d;

  // Bus decode; one cycle of ack per request, dropped the cycle after
  assign take = I_WB_CYC & I_WB_STB & ~ack_q;
  assign rd_take = take & ~I_WB_WE;
  assign wr_take = take & I_WB_WE & I_WB_SEL[0];
  // Byte address; the two low bits are ignored
  assign idx = I_WB_ADR[IDX_W+1:2];

  assign clr_st2 = rd_take && (idx == IDX_SECOND_ST);
  assign clr_st1 = rd_take && (idx == IDX_FIRST_ST);
  assign clr_fc = rd_take && (idx == IDX_FALSE_CAR);
  assign clr_re = rd_take && (idx == IDX_RX_ERR);

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Read data snapshot taken at the same edge as the clearing side effects
  always_comb begin
    rdat_d = '0;
    case (idx)
      IDX_INT_CTRL: begin
        rdat_d[CTRL_INT_EN_BIT] = ctrl_q[1];
        rdat_d[CTRL_INT_OE_BIT] = ctrl_q[0];
      end
      IDX_FIRST_ST: begin
        rdat_d[ST1_FC_HF_BIT] = st1_q[1];
        rdat_d[ST1_RE_HF_BIT] = st1_q[0];
        rdat_d[ST1_FC_EN_BIT] = en1_q[1];
        rdat_d[ST1_RE_EN_BIT] = en1_q[0];
      end
      IDX_SECOND_ST: begin
        // Bits 15 and 7 stay zero
        rdat_d[ST2_STAT_LSB +: NUM_EVT] = st2_q;
        rdat_d[ST2_EN_LSB +: NUM_EVT] = en2_q;
      end
      IDX_FALSE_CAR: begin
        rdat_d[FC_W-1:0] = fc_q;
      end
      IDX_RX_ERR: begin
        rdat_d[RE_W-1:0] = re_q;
      end
      default: begin
        rdat_d = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      rdat_q <= '0;
    end else if (rd_take) begin
      rdat_q <= rdat_d;
    end
  end

  // Writable control and enable fields; only the low byte lane holds them
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      ctrl_q <= RST_PAIR;
      en1_q <= RST_PAIR;
      en2_q <= RST_EVT;
    end else if (wr_take) begin
      if (idx == IDX_INT_CTRL) begin
        ctrl_q <= {I_WB_DAT[CTRL_INT_EN_BIT], I_WB_DAT[CTRL_INT_OE_BIT]};
      end
      if (idx == IDX_FIRST_ST) begin
        en1_q <= {I_WB_DAT[ST1_FC_EN_BIT], I_WB_DAT[ST1_RE_EN_BIT]};
      end
      if (idx == IDX_SECOND_ST) begin
        en2_q <= I_WB_DAT[ST2_EN_LSB +: NUM_EVT];
      end
    end
  end

  assign evt = {I_AN_ERR_EVT, I_PAGE_RX_EVT, I_LB_FIFO_EVT, I_XOVER_CHG_EVT,
                I_SLEEP_EVT, I_POL_CHG_EVT, I_JABBER};

  // Sticky status per event except jabber; a new event beats a clearing read
  for (genvar i = 0; i < NUM_EVT; i++) begin : g_st2
    always_ff @(posedge I_CLOCK) begin
      if (!I_RSTN) begin
        st2_q[i] <= RST_EVT[i];
      end else if (EVT_COR_MASK[i]) begin
        // Set whatever the enable says
        st2_q[i] <= (st2_q[i] & ~clr_st2) | evt[i];
      end else begin
        // Jabber bit mirrors the condition, so reading cannot hide it
        // Limitation: a jabber pulse between two reads is not remembered
        st2_q[i] <= evt[i];
      end
    end
  end

  // False carrier counter, saturating
  assign fc_inc = I_FALSE_CARRIER_EVT && (fc_q != FC_MAX);
  assign fc_hf_evt = I_FALSE_CARRIER_EVT && (fc_q == FC_HALF);

  always_comb begin
    fc_d = fc_q;
    if (clr_fc) begin
      // Increment in the clearing cycle is kept
      fc_d = I_FALSE_CARRIER_EVT ? {{(FC_W-1){1'b0}}, 1'b1} : RST_FC;
    end else if (fc_inc) begin
      fc_d = fc_q + 8'h01;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      fc_q <= RST_FC;
    end else begin
      fc_q <= fc_d;
    end
  end

  // Receive error counter, qualified and saturating
  assign re_evt = I_RX_ERR_EVT && I_CARRIER_VALID && I_RX_DV && !I_MII_LOOPBACK;
  assign re_inc = re_evt && (re_q != RE_MAX);
  assign re_hf_evt = re_evt && (re_q == RE_HALF);

  always_comb begin
    re_d = re_q;
    if (clr_re) begin
      re_d = re_evt ? {{(RE_W-1){1'b0}}, 1'b1} : RST_RE;
    end else if (re_inc) begin
      re_d = re_q + 16'h0001;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      re_q <= RST_RE;
    end else begin
      re_q <= re_d;
    end
  end

  // Half-full events latched in the first status register
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      st1_q <= RST_PAIR;
    end else begin
      st1_q <= (st1_q & {2{~clr_st1}}) | {fc_hf_evt, re_hf_evt};
    end
  end

  // Interrupt pin only drives when configured as output; active low
  assign irq_d = ctrl_q[1] && ctrl_q[0] &&
                 (|(st2_q & en2_q) || |(st1_q & en1_q));

  // Pin level kept in its own flop so the output carries no inverter
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      O_IRQ_N <= 1'b1;
      O_IRQ_OE <= 1'b0;
    end else begin
      O_IRQ_N <= ~irq_d;
      O_IRQ_OE <= ctrl_q[0];
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  ack_one_cycle_a: assert property (ack_q |=> !ack_q)
    else $error("ack held for more than one cycle");
  st2_clear_read_a: assert property (clr_st2 && !(|(evt & EVT_COR_MASK)) |=>
      ((st2_q & EVT_COR_MASK) == '0))
    else $error("second status not cleared by read");
  st2_set_evt_a: assert property (I_AN_ERR_EVT |=> st2_q[6] [*1])
    else $error("autoneg error event not latched");
  st2_unenabled_set_a: assert property (I_POL_CHG_EVT && !en2_q[1] |=> st2_q[1])
    else $error("status not set while enable is clear");
  jabber_live_a: assert property (st2_q[0] == $past(I_JABBER))
    else $error("jabber bit does not follow condition");
  st2_reserved_a: assert property (rd_take && idx == IDX_SECOND_ST |=>
      O_WB_ACK && O_WB_DAT[15] == 1'b0 && O_WB_DAT[7] == 1'b0)
    else $error("reserved bits read non-zero");
  fc_saturate_a: assert property (fc_q == FC_MAX && !clr_fc |=> fc_q == FC_MAX)
    else $error("false carrier counter wrapped");
  fc_count_a: assert property (I_FALSE_CARRIER_EVT && !clr_fc && fc_q != FC_MAX |=>
      fc_q == $past(fc_q) + 8'h01)
    else $error("false carrier counter missed an event");
  fc_half_a: assert property (fc_hf_evt |=> st1_q[1])
    else $error("false carrier half-full not latched");
  fc_clear_keep_a: assert property (clr_fc |=> fc_q == {7'h00, $past(I_FALSE_CARRIER_EVT)})
    else $error("false carrier clear lost an event");
  re_loop_hold_a: assert property (I_MII_LOOPBACK && !clr_re |=> re_q == $past(re_q))
    else $error("receive error counter moved in loopback");
  re_saturate_a: assert property (re_q == RE_MAX && !clr_re |=> re_q == RE_MAX)
    else $error("receive error counter wrapped");
  re_half_a: assert property (re_hf_evt |=> st1_q[0] ##1 !O_IRQ_N || !(ctrl_q == 2'h3 && en1_q[0]))
    else $error("receive error half-full not raised");
  irq_gate_a: assert property (ctrl_q != 2'h3 |=> O_IRQ_N)
    else $error("interrupt raised without both control bits");
  irq_oe_a: assert property (##1 O_IRQ_OE == $past(ctrl_q[0]))
    else $error("interrupt pin enable does not follow control");
  rx_count_a: assert property (re_evt && !clr_re && re_q != RE_MAX |=>
      re_q == $past(re_q) + 16'h0001)
    else $error("receive error counter missed an error");

  // Each event sets its own status bit
  st2_page_set_a: assert property (I_PAGE_RX_EVT |=> st2_q[5])
    else $error("page received event not latched");
  st2_fifo_set_a: assert property (I_LB_FIFO_EVT |=> st2_q[4])
    else $error("loopback fifo event not latched");
  st2_xover_set_a: assert property (I_XOVER_CHG_EVT |=> st2_q[3])
    else $error("crossover change event not latched");
  st2_sleep_set_a: assert property (I_SLEEP_EVT |=> st2_q[2])
    else $error("sleep event not latched");
  st2_pol_set_a: assert property (I_POL_CHG_EVT |=> st2_q[1])
    else $error("polarity change event not latched");
  st2_sticky_a: assert property (!clr_st2 |=>
      ((st2_q & $past(st2_q) & EVT_COR_MASK) == ($past(st2_q) & EVT_COR_MASK)))
    else $error("pending status lost without a read");
  jabber_read_a: assert property (clr_st2 && I_JABBER |=> st2_q[0])
    else $error("jabber bit cleared by a read");

  // Read data is the snapshot taken at the accepting edge
  st2_read_data_a: assert property (rd_take && idx == IDX_SECOND_ST |=>
      O_WB_DAT[14:8] == $past(st2_q) && O_WB_DAT[6:0] == $past(en2_q))
    else $error("second status read data wrong");
  st1_read_data_a: assert property (rd_take && idx == IDX_FIRST_ST |=>
      O_WB_DAT[9:8] == $past(st1_q) && O_WB_DAT[1:0] == $past(en1_q))
    else $error("first status read data wrong");
  fc_read_data_a: assert property (rd_take && idx == IDX_FALSE_CAR |=>
      O_WB_DAT == {24'h000000, $past(fc_q)})
    else $error("false carrier read data wrong");
  re_read_data_a: assert property (rd_take && idx == IDX_RX_ERR |=>
      O_WB_DAT == {16'h0000, $past(re_q)})
    else $error("receive error read data wrong");
  st1_clear_a: assert property (clr_st1 && !fc_hf_evt && !re_hf_evt |=>
      st1_q == 2'h0)
    else $error("first status not cleared by read");
  re_clear_keep_a: assert property (clr_re |=> re_q == {15'h0000, $past(re_evt)})
    else $error("receive error clear lost an error");

  // Writable fields change only on an accepted write
  en2_write_a: assert property (wr_take && idx == IDX_SECOND_ST |=>
      en2_q == $past(I_WB_DAT[6:0]))
    else $error("second status enables not written");
  en1_write_a: assert property (wr_take && idx == IDX_FIRST_ST |=>
      en1_q == $past(I_WB_DAT[1:0]))
    else $error("half-full enables not written");
  ctrl_write_a: assert property (wr_take && idx == IDX_INT_CTRL |=>
      ctrl_q == $past(I_WB_DAT[1:0]))
    else $error("interrupt control not written");
  en_hold_a: assert property (!wr_take |=>
      $stable(en2_q) && $stable(en1_q) && $stable(ctrl_q))
    else $error("enable changed without a write");

  // Counters move only on qualified events or a clearing read
  fc_idle_a: assert property (!I_FALSE_CARRIER_EVT && !clr_fc |=>
      fc_q == $past(fc_q))
    else $error("false carrier counter moved without event");
  fc_half_only_a: assert property (!st1_q[1] && !fc_hf_evt |=> !st1_q[1])
    else $error("false carrier half-full set without crossing");
  re_half_only_a: assert property (!st1_q[0] && !re_hf_evt |=> !st1_q[0])
    else $error("receive error half-full set without crossing");
  re_no_dv_a: assert property (!I_RX_DV && !clr_re |=>
      re_q == $past(re_q))
    else $error("receive error counted without data valid");
  re_no_cv_a: assert property (!I_CARRIER_VALID && !clr_re |=>
      re_q == $past(re_q))
    else $error("receive error counted without carrier");

  // Interrupt pin level against its causes
  irq_raise_a: assert property (ctrl_q == 2'h3 &&
      (|(st2_q & en2_q) || |(st1_q & en1_q)) |=> !O_IRQ_N)
    else $error("enabled pending event raised no interrupt");
  irq_quiet_a: assert property (!(|(st2_q & en2_q)) && !(|(st1_q & en1_q)) |=>
      O_IRQ_N)
    else $error("interrupt raised with nothing pending");

  // Main scenarios the bench must reach
  read_cov_c: cover property (clr_st2 && st2_q[6]);
  fc_full_c: cover property (fc_q == FC_MAX);
  irq_c: cover property (!O_IRQ_N && O_IRQ_OE);
  clr_race_c: cover property (clr_re && re_evt);
  fc_race_c: cover property (clr_fc && I_FALSE_CARRIER_EVT);

endmodule : pesc_top

// File: verilog/pesc_pkg.sv
// Purpose: Constants for the PHY event status and error counter block
// Assumes: Register indexes are word indexes; byte address is index times four
// Notes: Counter ceilings and half-full marks are fixed by the register layout
package pesc_pkg;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 6;
  localparam int NUM_EVT = 7;
  localparam int FC_W = 8;
  localparam int RE_W = 16;

  // Word indexes of the registers
  localparam logic [IDX_W-1:0] IDX_INT_CTRL = 6'h11;
  localparam logic [IDX_W-1:0] IDX_FIRST_ST = 6'h12;
  localparam logic [IDX_W-1:0] IDX_SECOND_ST = 6'h13;
  localparam logic [IDX_W-1:0] IDX_FALSE_CAR = 6'h14;
  localparam logic [IDX_W-1:0] IDX_RX_ERR = 6'h15;

  // Field positions
  localparam int CTRL_INT_EN_BIT = 1;
  localparam int CTRL_INT_OE_BIT = 0;
  localparam int ST1_FC_HF_BIT = 9;
  localparam int ST1_RE_HF_BIT = 8;
  localparam int ST1_FC_EN_BIT = 1;
  localparam int ST1_RE_EN_BIT = 0;
  localparam int ST2_STAT_LSB = 8;
  localparam int ST2_EN_LSB = 0;

  // Event vector order: 6 autoneg error .. 0 jabber; jabber does not clear on read
  localparam logic [NUM_EVT-1:0] EVT_COR_MASK = 7'h7e;

  // Reset values
  localparam logic [NUM_EVT-1:0] RST_EVT = 7'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;
  localparam logic [FC_W-1:0] RST_FC = 8'h00;
  localparam logic [RE_W-1:0] RST_RE = 16'h0000;

  // Counter limits
  localparam logic [FC_W-1:0] FC_MAX = 8'hff;
  localparam logic [FC_W-1:0] FC_HALF = 8'h7f;
  localparam logic [RE_W-1:0] RE_MAX = 16'hffff;
  localparam logic [RE_W-1:0] RE_HALF = 16'h7fff;
endpackage : pesc_pkg

// File: sim/pesc_mac_model.sv
// Purpose: Management master model issuing classic Wishbone cycles
// Assumes: Slave answers each request with a registered ack
// Notes: No wait limit here; the bench timeout cuts a hang
`timescale 1ns/1ps
module pesc_mac_model
  import pesc_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic [DATA_W-1:0] i_dat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [ADR_W-1:0] o_adr,
  output logic [3:0] o_sel,
  output logic [DATA_W-1:0] o_dat
);
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = '0;
    o_sel = 4'h0;
    o_dat = '0;
  end

  // Request held until ack is sampled, released only at that edge
  task automatic xfer(input logic we, input logic [ADR_W-1:0] adr,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    @(posedge i_clock);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= we;
    o_adr <= adr;
    o_sel <= 4'hf;
    o_dat <= wd;
    do @(posedge i_clock); while (i_ack !== 1'b1);
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we <= 1'b0;
    // Stale data would hide a slave that latches late
    o_dat <= ~wd;
  endtask : xfer
endmodule : pesc_mac_model

// File: sim/tb_pesc_top.sv
// Purpose: Register level test of event status and error counters
// Assumes: Events driven as held levels count once per edge
// Notes: Receive error saturation needs about 66k cycles
`timescale 1ns/1ps
module tb_pesc_top;
  import pesc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] ev = '0;
  logic cv = 1'b0;
  logic dv = 1'b0;
  logic lb = 1'b0;
  logic cyc, stb, we, ack, irq_n, irq_oe;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [DATA_W-1:0] wd, rdat;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;

  always #2.5 clk = ~clk;

  pesc_mac_model i_pesc_mac_model (.i_clock(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
    .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wd));

  pesc_top i_pesc_top (.I_CLOCK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_AN_ERR_EVT(ev[6]), .I_PAGE_RX_EVT(ev[5]), .I_LB_FIFO_EVT(ev[4]),
    .I_XOVER_CHG_EVT(ev[3]), .I_SLEEP_EVT(ev[2]), .I_POL_CHG_EVT(ev[1]), .I_JABBER(ev[0]),
    .I_FALSE_CARRIER_EVT(ev[7]), .I_RX_ERR_EVT(ev[8]), .I_CARRIER_VALID(cv), .I_RX_DV(dv),
    .I_MII_LOOPBACK(lb), .O_IRQ_N(irq_n), .O_IRQ_OE(irq_oe));

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    i_pesc_mac_model.xfer(1'b1, a, d, v);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    i_pesc_mac_model.xfer(1'b0, a, 32'h0, v);
    chk(name, v, e);
  endtask : rdc

  // Source held high for n edges
  task automatic hold(input int b, input int n);
    @(posedge clk);
    ev[b] <= 1'b1;
    repeat (n) @(posedge clk);
    ev[b] <= 1'b0;
  endtask : hold

  // Irq register lags its cause by two edges; three gives margin
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("irq_n", {31'h0, irq_n}, {31'h0, e});
  endtask : irq_is

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rdc("ctrl", 8'h44, 32'h0);
    rdc("st1", 8'h48, 32'h0);
    rdc("st2", 8'h4c, 32'h0);
    rdc("fc", 8'h50, 32'h0);
    rdc("re", 8'h54, 32'h0);
    rdc("unmapped", 8'h7c, 32'h0);
    wr(8'h4c, 32'hffffffff);
    rdc("st2 en", 8'h4c, 32'h7f);
    wr(8'h4c, 32'h0);
    for (k = 6; k >= 1; k--) begin
      hold(k, 1);
      rdc("st2 evt", 8'h4c, 32'h1 << (k + 8));
      rdc("st2 cor", 8'h4c, 32'h0);
    end
    @(posedge clk);
    ev[0] <= 1'b1;
    rdc("jab", 8'h4c, 32'h100);
    rdc("jab kept", 8'h4c, 32'h100);
    @(posedge clk);
    ev[0] <= 1'b0;
    rdc("jab gone", 8'h4c, 32'h0);
    wr(8'h44, 32'h3);
    wr(8'h4c, 32'h40);
    hold(6, 1);
    irq_is(1'b0);
    chk("irq_oe", {31'h0, irq_oe}, 32'h1);
    rdc("st2 an", 8'h4c, 32'h4040);
    irq_is(1'b1);
    hold(5, 1);
    irq_is(1'b1);
    wr(8'h44, 32'h2);
    wr(8'h4c, 32'h20);
    irq_is(1'b1);
    chk("irq_oe off", {31'h0, irq_oe}, 32'h0);
    rdc("st2 page", 8'h4c, 32'h2020);
    wr(8'h4c, 32'h0);
    wr(8'h44, 32'h3);
    wr(8'h48, 32'h2);
    hold(7, 128);
    irq_is(1'b0);
    rdc("fc 80", 8'h50, 32'h80);
    rdc("st1 fc", 8'h48, 32'h202);
    irq_is(1'b1);
    hold(7, 300);
    rdc("fc sat", 8'h50, 32'hff);
    rdc("fc cor", 8'h50, 32'h0);
    rdc("st1 fc2", 8'h48, 32'h202);
    fork
      hold(7, 3);
      rdc("fc race", 8'h50, 32'h0);
    join
    rdc("fc kept", 8'h50, 32'h3);
    fork
      hold(6, 1);
      rdc("st2 race", 8'h4c, 32'h0);
    join
    rdc("st2 kept", 8'h4c, 32'h4000);
    @(posedge clk);
    cv <= 1'b1;
    dv <= 1'b1;
    lb <= 1'b1;
    hold(8, 5);
    rdc("re lb", 8'h54, 32'h0);
    lb <= 1'b0;
    dv <= 1'b0;
    hold(8, 5);
    rdc("re no dv", 8'h54, 32'h0);
    cv <= 1'b0;
    dv <= 1'b1;
    hold(8, 5);
    rdc("re no cv", 8'h54, 32'h0);
    cv <= 1'b1;
    hold(8, 3);
    rdc("re 3", 8'h54, 32'h3);
    hold(8, 32768);
    rdc("st1 re", 8'h48, 32'h102);
    hold(8, 32768);
    rdc("re sat", 8'h54, 32'hffff);
    rdc("re cor", 8'h54, 32'h0);
    wr(8'h44, 32'h3);
    wr(8'h4c, 32'h7f);
    hold(6, 1);
    irq_is(1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("irq_n rst", {31'h0, irq_n}, 32'h1);
    chk("irq_oe rst", {31'h0, irq_oe}, 32'h0);
    rdc("st2 rst", 8'h4c, 32'h0);
    rdc("st1 rst", 8'h48, 32'h0);
    rdc("ctrl rst", 8'h44, 32'h0);
    wrap_up();
  end
endmodule : tb_pesc_top
